// ---- bench/tlbd_core_model.sv ----
// Purpose: core side model issuing translation lookups
// Assumes: one lookup at a time, answer one cycle after the request
// Notes:   released request fields are inverted so stale values never look usable
`timescale 1ns/1ns
module tlbd_core_model
  import tlbd_pkg::*;
(
  input  wire logic         sys_clk_i,
  output tlbd_req_type      xlat_req_o,
  input  wire tlbd_rsp_type xlat_rsp_i
);
  initial xlat_req_o = '0;

  task automatic lookup(input logic [IDX_W-1:0] idx, input logic [VOFS_W-1:0] vofs,
                        input logic priv, input logic wr, output tlbd_rsp_type rsp);
    tlbd_req_type r;
    @(posedge sys_clk_i);
    xlat_req_o <= '{vld: 1'b1, index: idx, vofs: vofs, priv: priv, write: wr};
    @(posedge sys_clk_i);
    r = ~xlat_req_o;
    r.vld = 1'b0;
    xlat_req_o <= r;
    @(negedge sys_clk_i);
    rsp = xlat_rsp_i;
  endtask
endmodule // tlbd_core_model

// ---- bench/tlbd_entry_data_bench.sv ----
// Purpose: self-checking bench for the tlb entry data block
// Assumes: avalon master and core model driven on rising edges
// Notes:   expectations rebuilt from the protection table, not from the design
`timescale 1ns/1ns
module tlbd_entry_data_bench
  import tlbd_pkg::*;
;
  logic              sys_clk_i;
  logic              reset_n_i;
  logic              manual_reset_i;
  logic [ADDR_W-1:0] avs_address_i;
  logic              avs_read_i;
  logic              avs_write_i;
  logic [DATA_W-1:0] avs_writedata_i;
  logic [BE_W-1:0]   avs_byteenable_i;
  logic [DATA_W-1:0] avs_readdata_o;
  logic              avs_waitrequest_o;
  tlbd_req_type      xlat_req;
  tlbd_rsp_type      xlat_rsp;
  logic              irq_o;
  int                error_cnt;
  int                n_tests;
  tlbd_rsp_type      rsp;

  tlbd_entry_data u_tlbd_entry_data (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .manual_reset_i(manual_reset_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .xlat_req_i(xlat_req), .xlat_rsp_o(xlat_rsp), .irq_o(irq_o));
  tlbd_core_model u_tlbd_core_model (.sys_clk_i(sys_clk_i), .xlat_req_o(xlat_req), .xlat_rsp_i(xlat_rsp));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic fail(input string m);
    $display("unexpected at %0t: %s", $time, m);
    error_cnt++;
  endtask

  task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) fail("register or flag word differs");
  endtask

  task automatic chk_rsp(input tlbd_rsp_type got, input tlbd_rsp_type exp);
    n_tests++;
    if (got !== exp) fail("translation response differs");
  endtask

  // bench waits for waitrequest low however long it takes; only the watchdog ends a hang
  task automatic avm(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge sys_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  // byte enables settle a cycle before the request and return to all-on after it
  task automatic wr_be(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] q;
    @(posedge sys_clk_i);
    avs_byteenable_i <= be;
    avm(1'b1, a, d, q);
    avs_byteenable_i <= 4'hf;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    avm(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] q;
    avm(1'b0, a, '0, q);
    chk_word(q, exp);
  endtask

  task automatic set_entry(input int i, input logic [PPN_W-1:0] physical_page_number, input logic [5:0] f);
    wr(ADDR_W'(32 + 8 * i), {3'h0, physical_page_number});
    wr(ADDR_W'(36 + 8 * i), {26'h0, f});
  endtask

  // f: valid, protection_code, cacheable, dirty, size4k from bit 0 up
  function automatic tlbd_rsp_type exp_rsp(input logic [PPN_W-1:0] physical_page_number, input logic [5:0] f,
                                           input logic [VOFS_W-1:0] vofs, input logic priv, input logic w);
    tlbd_rsp_type e;
    logic         ok;
    e = '0;
    e.done = 1'b1;
    ok = priv ? (!w || f[1]) : (f[2] && (!w || f[1]));
    if (!f[0]) e.miss = 1'b1;
    else if (!ok) e.viol = 1'b1;
    else begin
      e.grant = 1'b1;
      e.cache = f[3];
      e.dirty = f[4];
      e.paddr = {physical_page_number, vofs[OFS_W-1:0]};
      if (f[5]) e.paddr[11:10] = vofs[11:10];
    end
    return e;
  endfunction

  task automatic do_reset;
    reset_n_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
  endtask

  task automatic t_regs;
    rd_chk(STATUS_OFS, 32'h0);
    rd_chk(MASK_OFS, 32'h0);
    rd_chk(6'h3c, 32'h0);
    wr(6'h08, 32'hffffffff);
    rd_chk(6'h08, 32'h0);
    wr(6'h3c, 32'hffffffc0);
    rd_chk(6'h3c, 32'h0);
    $display("test regs done");
  endtask

  // every code against every privilege and direction; dirty and cache ride along
  task automatic t_prot;
    logic [5:0] f;
    for (int p = 0; p < 4; p++) begin
      f = {1'b0, p[0], p[1], p[1:0], 1'b1};
      set_entry(1, 29'h1abcd123, f);
      for (int m = 0; m < 4; m++) begin
        u_tlbd_core_model.lookup(2'h1, 12'h35a, m[1], m[0], rsp);
        chk_rsp(rsp, exp_rsp(29'h1abcd123, f, 12'h35a, m[1], m[0]));
      end
    end
    $display("test prot done");
  endtask

  task automatic t_size4k;
    set_entry(2, 29'h1abcd123, 6'h27);
    u_tlbd_core_model.lookup(2'h2, 12'h75a, 1'b0, 1'b1, rsp);
    chk_rsp(rsp, exp_rsp(29'h1abcd123, 6'h27, 12'h75a, 1'b0, 1'b1));
    wr_be(6'h30, 32'hffff55ff, 4'h2);
    rd_chk(6'h30, 32'h1abc5523);
    $display("test size4k done");
  endtask

  task automatic t_irq;
    rd_chk(STATUS_OFS, 32'h1);
    wr(STATUS_OFS, 32'h3);
    u_tlbd_core_model.lookup(2'h3, 12'h001, 1'b1, 1'b0, rsp);
    chk_rsp(rsp, exp_rsp(29'h0, 6'h00, 12'h001, 1'b1, 1'b0));
    rd_chk(STATUS_OFS, 32'h2);
    chk_word({31'h0, irq_o}, 32'h0);
    wr(MASK_OFS, 32'h3);
    @(negedge sys_clk_i);
    chk_word({31'h0, irq_o}, 32'h1);
    set_entry(1, 29'h5, 6'h01);
    u_tlbd_core_model.lookup(2'h1, 12'h002, 1'b0, 1'b0, rsp);
    chk_rsp(rsp, exp_rsp(29'h5, 6'h01, 12'h002, 1'b0, 1'b0));
    rd_chk(STATUS_OFS, 32'h3);
    wr(STATUS_OFS, 32'h2);
    rd_chk(STATUS_OFS, 32'h1);
    wr(STATUS_OFS, 32'h1);
    @(negedge sys_clk_i);
    chk_word({31'h0, irq_o}, 32'h0);
    $display("test irq done");
  endtask

  task automatic t_manual;
    set_entry(0, 29'h777, 6'h0f);
    @(posedge sys_clk_i);
    manual_reset_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    manual_reset_i <= 1'b0;
    rd_chk(MASK_OFS, 32'h0);
    rd_chk(6'h24, 32'h1);
    u_tlbd_core_model.lookup(2'h0, 12'h123, 1'b1, 1'b0, rsp);
    chk_rsp(rsp, exp_rsp(29'h0, 6'h01, 12'h123, 1'b1, 1'b0));
    @(posedge sys_clk_i);
    do_reset;
    u_tlbd_core_model.lookup(2'h0, 12'h123, 1'b1, 1'b0, rsp);
    chk_rsp(rsp, exp_rsp(29'h0, 6'h00, 12'h123, 1'b1, 1'b0));
    $display("test manual done");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // the whole run is under two hundred cycles, so 5000 means a hang
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fail("watchdog expired");
    give_verdict;
  end

  initial begin
    error_cnt = 0;
    n_tests = 0;
    reset_n_i = 1'b0;
    manual_reset_i = 1'b0;
    avs_address_i = '0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = '0;
    avs_byteenable_i = 4'hf;
    do_reset;
    t_regs;
    t_prot;
    t_size4k;
    t_irq;
    t_manual;
    give_verdict;
  end
endmodule // tlbd_entry_data_bench

// ---- verilog/tlbd_entry_data.sv ----
// Purpose: data half of the tlb entries, translation and protection check
// Assumes: core presents the hit entry index; manual reset comes from core-clock logic
// Notes:   lookup answer is registered, one cycle after the request
`timescale 1ns/1ns
module tlbd_entry_data
  import tlbd_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              manual_reset_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [DATA_W-1:0] avs_writedata_i,
  input  wire logic [BE_W-1:0]   avs_byteenable_i,
  output logic      [DATA_W-1:0] avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire tlbd_req_type      xlat_req_i,
  output tlbd_rsp_type           xlat_rsp_o,
  output logic                   irq_o
);

  logic [NUM_ENTRIES-1:0] valid_r;
  tlbd_entry_type         ent_r [NUM_ENTRIES];
  logic [STS_W-1:0]       status_r;
  logic [STS_W-1:0]       status_nxt;
  logic [STS_W-1:0]       mask_r;
  logic                   ack_r;
  logic [DATA_W-1:0]      rdata_r;
  logic [DATA_W-1:0]      rd_cur;
  logic [DATA_W-1:0]      bmask;
  logic [DATA_W-1:0]      merged;
  logic                   wr_acc;
  logic                   is_entry;
  logic                   is_flags;
  logic [IDX_W-1:0]       wr_idx;
  tlbd_rsp_type           rsp_r;
  tlbd_rsp_type           rsp_nxt;
  tlbd_entry_type         sel_ent;
  logic                   sel_valid;
  logic                   allow;
  logic                   lookup;

  // avalon slave: one wait cycle, then answer
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_readdata_o    = rdata_r;
  // writes are dropped while the manual reset holds the block
  assign wr_acc            = avs_write_i & ack_r & ~manual_reset_i;
  assign is_entry          = avs_address_i[ENTRY_SEL_BIT];
  assign is_flags          = avs_address_i[WORD_SEL_BIT];
  assign wr_idx            = avs_address_i[IDX_LSB +: IDX_W];

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
    end
  end

  always_comb begin
    bmask = '0;
    for (int b = 0; b < BE_W; b++) begin
      bmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
    end
  end

  // readback of the addressed word; unmapped addresses read zero
  always_comb begin
    rd_cur = '0;
    if (is_entry) begin
      if (is_flags) begin
        rd_cur[FLG_VALID]       = valid_r[wr_idx];
        rd_cur[FLG_PROT +: 2]   = ent_r[wr_idx].prot;
        rd_cur[FLG_CACHE]       = ent_r[wr_idx].cache;
        rd_cur[FLG_DIRTY]       = ent_r[wr_idx].dirty;
        rd_cur[FLG_SIZE4K]      = ent_r[wr_idx].size4k;
      end else begin
        rd_cur[PPN_W-1:0]       = ent_r[wr_idx].physical_page_number;
      end
    end else if (avs_address_i == STATUS_OFS) begin
      rd_cur[STS_W-1:0] = status_r;
    end else if (avs_address_i == MASK_OFS) begin
      rd_cur[STS_W-1:0] = mask_r;
    end
  end

  assign merged = (rd_cur & ~bmask) | (avs_writedata_i & bmask);

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rdata_r <= '0;
    end else if (avs_read_i & ~ack_r) begin
      rdata_r <= rd_cur;
    end
  end

  // per-entry storage; valid sits apart since of the two resets only power-on clears it
  for (genvar i = 0; i < NUM_ENTRIES; i++) begin : g_entry
    always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
        valid_r[i] <= 1'b0;
      end else if (wr_acc && is_entry && is_flags && wr_idx == IDX_W'(i)) begin
        valid_r[i] <= merged[FLG_VALID];
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i || manual_reset_i) begin
        ent_r[i] <= '0;
      end else if (wr_acc && is_entry && wr_idx == IDX_W'(i)) begin
        if (is_flags) begin
          ent_r[i].prot   <= merged[FLG_PROT +: 2];
          ent_r[i].cache  <= merged[FLG_CACHE];
          ent_r[i].dirty  <= merged[FLG_DIRTY];
          ent_r[i].size4k <= merged[FLG_SIZE4K];
        end else begin
          ent_r[i].physical_page_number    <= merged[PPN_W-1:0];
        end
      end
    end
  end

  // translation path
  assign lookup    = xlat_req_i.vld & ~manual_reset_i;
  assign sel_ent   = ent_r[xlat_req_i.index];
  assign sel_valid = valid_r[xlat_req_i.index];

  tlbd_prot_check u_prot (
    .prot_i  (sel_ent.prot),
    .priv_i  (xlat_req_i.priv),
    .write_i (xlat_req_i.write),
    .allow_o (allow)
  );

  always_comb begin
    rsp_nxt       = '0;
    rsp_nxt.done  = lookup;
    rsp_nxt.miss  = lookup & ~sel_valid;
    rsp_nxt.viol  = lookup & sel_valid & ~allow;
    rsp_nxt.grant = lookup & sel_valid & allow;
    if (rsp_nxt.grant) begin
      rsp_nxt.cache = sel_ent.cache;
      rsp_nxt.dirty = sel_ent.dirty;
      rsp_nxt.paddr = {sel_ent.physical_page_number, xlat_req_i.vofs[OFS_W-1:0]};
      if (sel_ent.size4k) begin
        rsp_nxt.paddr[VOFS_W-1:OFS_W] = xlat_req_i.vofs[VOFS_W-1:OFS_W];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || manual_reset_i) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  assign xlat_rsp_o = rsp_r;

  // sticky status, write one to clear; a new event wins over the clear
  always_comb begin
    status_nxt = status_r;
    if (wr_acc && !is_entry && avs_address_i == STATUS_OFS) begin
      status_nxt = status_r & ~(avs_writedata_i[STS_W-1:0] & bmask[STS_W-1:0]);
    end
    status_nxt[STS_VIOL] = status_nxt[STS_VIOL] | rsp_r.viol;
    status_nxt[STS_MISS] = status_nxt[STS_MISS] | rsp_r.miss;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || manual_reset_i) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || manual_reset_i) begin
      mask_r <= '0;
    end else if (wr_acc && !is_entry && avs_address_i == MASK_OFS) begin
      mask_r <= merged[STS_W-1:0];
    end
  end

  assign irq_o = |(status_r & mask_r);

  // checks
  sequence s_hit_lookup;
    lookup && sel_valid;
  endsequence

  sequence s_user_or_write;
    !xlat_req_i.priv || xlat_req_i.write;
  endsequence

  valid_por_a: assert property (@(posedge sys_clk_i) !reset_n_i |=> valid_r == '0)
    else $error("valid flags not cleared by power-on reset");

  valid_keep_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    manual_reset_i |=> valid_r == $past(valid_r))
    else $error("manual reset disturbed valid flags");

  miss_block_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || manual_reset_i)
    lookup && !sel_valid |=> rsp_r.done && rsp_r.miss && !rsp_r.grant && rsp_r.paddr == '0)
    else $error("invalid entry used for translation");

  prot_ro_priv_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || manual_reset_i)
    s_hit_lookup ##0 (sel_ent.prot == PROT_PRIV_RO) ##0 s_user_or_write |=> rsp_r.viol && !rsp_r.grant)
    else $error("code 00 let a write or user access through");

  prot_rw_priv_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || manual_reset_i)
    s_hit_lookup ##0 (sel_ent.prot == PROT_PRIV_RW)
      |=> rsp_r.grant == $past(xlat_req_i.priv) && rsp_r.viol == !$past(xlat_req_i.priv))
    else $error("code 01 decision wrong");

  prot_ro_all_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || manual_reset_i)
    s_hit_lookup ##0 (sel_ent.prot == PROT_ALL_RO) |=> rsp_r.grant == !$past(xlat_req_i.write))
    else $error("code 10 decision wrong");

  prot_rw_all_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || manual_reset_i)
    s_hit_lookup ##0 (sel_ent.prot == PROT_ALL_RW) |=> rsp_r.grant && !rsp_r.viol)
    else $error("code 11 refused an access");

  paddr_ppn_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || manual_reset_i)
    s_hit_lookup ##0 allow ##0 !sel_ent.size4k
      |=> rsp_r.paddr == {$past(sel_ent.physical_page_number), $past(xlat_req_i.vofs[OFS_W-1:0])})
    else $error("physical address not built from page number");

  paddr_4k_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || manual_reset_i)
    s_hit_lookup ##0 allow ##0 sel_ent.size4k
      |=> rsp_r.paddr[VOFS_W-1:0] == $past(xlat_req_i.vofs)
       && rsp_r.paddr[PA_W-1:VOFS_W] == $past(sel_ent.physical_page_number[PPN_W-1:VOFS_W-OFS_W]))
    else $error("4-kbyte page address bits wrong");

  cache_flag_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || manual_reset_i)
    s_hit_lookup ##0 allow |=> rsp_r.cache == $past(sel_ent.cache) && rsp_r.dirty == $past(sel_ent.dirty))
    else $error("cacheable or dirty flag not passed to core");

  dirty_store_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || manual_reset_i)
    wr_acc && is_entry && is_flags |=> ent_r[$past(wr_idx)].dirty == $past(merged[FLG_DIRTY]))
    else $error("dirty flag write lost");

  viol_irq_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || manual_reset_i)
    rsp_r.viol && mask_r[STS_VIOL] |=> status_r[STS_VIOL] && irq_o)
    else $error("violation not reported");

endmodule // tlbd_entry_data

// ---- verilog/tlbd_pkg.sv ----
// Purpose: shared constants and carriers for the tlb entry data block
// Assumes: 32-bit avalon data, byte addresses, 10 MHz core clock
// Notes:   four entries, protection encodings, register layout
package tlbd_pkg;

  localparam int unsigned NUM_ENTRIES = 4;
  localparam int unsigned IDX_W       = 2;
  localparam int unsigned PPN_W       = 29;
  localparam int unsigned OFS_W       = 10;
  localparam int unsigned VOFS_W      = 12;
  localparam int unsigned PA_W        = PPN_W + OFS_W;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADDR_W      = 6;
  localparam int unsigned BE_W        = 4;
  localparam int unsigned STS_W       = 2;

  // register map, byte addresses
  localparam logic [ADDR_W-1:0] STATUS_OFS = 6'h00;
  localparam logic [ADDR_W-1:0] MASK_OFS   = 6'h04;
  localparam int unsigned ENTRY_SEL_BIT = 5;
  localparam int unsigned IDX_LSB       = 3;
  localparam int unsigned WORD_SEL_BIT  = 2;

  // entry flag word layout
  localparam int unsigned FLG_VALID  = 0;
  localparam int unsigned FLG_PROT   = 1;
  localparam int unsigned FLG_CACHE  = 3;
  localparam int unsigned FLG_DIRTY  = 4;
  localparam int unsigned FLG_SIZE4K = 5;

  // status and mask layout
  localparam int unsigned STS_VIOL = 0;
  localparam int unsigned STS_MISS = 1;

  // protection codes
  localparam logic [1:0] PROT_PRIV_RO = 2'h0;
  localparam logic [1:0] PROT_PRIV_RW = 2'h1;
  localparam logic [1:0] PROT_ALL_RO  = 2'h2;
  localparam logic [1:0] PROT_ALL_RW  = 2'h3;

  typedef struct packed {
    logic [PPN_W-1:0] physical_page_number;
    logic [1:0]       prot;
    logic             cache;
    logic             dirty;
    logic             size4k;
  } tlbd_entry_type;

  typedef struct packed {
    logic              vld;
    logic [IDX_W-1:0]  index;
    logic [VOFS_W-1:0] vofs;
    logic              priv;
    logic              write;
  } tlbd_req_type;

  typedef struct packed {
    logic            done;
    logic            grant;
    logic            miss;
    logic            viol;
    logic            cache;
    logic            dirty;
    logic [PA_W-1:0] paddr;
  } tlbd_rsp_type;

endpackage

// ---- verilog/tlbd_prot_check.sv ----
// Purpose: decode a protection code against privilege and direction
// Assumes: purely combinational, same clock as caller
// Notes:   all four codes legal, so no default branch
`timescale 1ns/1ns
module tlbd_prot_check
  import tlbd_pkg::*;
(
  input  wire logic [1:0] prot_i,
  input  wire logic       priv_i,
  input  wire logic       write_i,
  output logic            allow_o
);

  always_comb begin
    unique case (prot_i)
      PROT_PRIV_RO: allow_o = priv_i & ~write_i;
      PROT_PRIV_RW: allow_o = priv_i;
      PROT_ALL_RO:  allow_o = ~write_i;
      PROT_ALL_RW:  allow_o = 1'b1;
    endcase
  end

endmodule // tlbd_prot_check
